// ==== shared/ovp_pkg.sv ====
/*
  Constants for output voltage feedback processing and overvoltage protection.
  Assumes a 100 MHz system clock; all times are converted here.
*/
package ovp_pkg;
  // Register offsets
  localparam logic [15:0] OFF_TRIP_LEVEL = 16'h0040;
  localparam logic [15:0] OFF_REACTION = 16'h0041;
  localparam logic [15:0] OFF_FAST_ACTION = 16'hFE01;
  localparam logic [15:0] OFF_OL_ACTION = 16'hFE02;
  localparam logic [15:0] OFF_FAST_RISE = 16'hFE2F;
  localparam logic [15:0] OFF_FAST_FALL = 16'hFE30;
  localparam logic [15:0] OFF_FAST_DEB = 16'hFE31;
  localparam logic [15:0] OFF_HYST = 16'hFE50;
  localparam logic [15:0] OFF_STATUS = 16'hFE90;
  // Field positions and reset values
  localparam int ACT_LSB = 6;
  localparam int LEVEL_W = 7;
  localparam logic [15:0] RST_TRIP_LEVEL = 16'h07FF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_LEVEL = 8'h7F;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_HZ = 100_000_000;
  localparam int BLANK_NS = 10_000;
  localparam int BLANK_CYC = BLANK_NS / CLK_PERIOD_NS;
  localparam int OL_DEB_NS = 10_000;
  localparam int OL_DEB_CYC = OL_DEB_NS / CLK_PERIOD_NS;
  localparam int FAST_UPDATE_HZ = 1500;
  localparam int FAST_PERIOD_CYC = CLK_HZ / FAST_UPDATE_HZ;
  localparam int DEB0_NS = 120;
  localparam int DEB1_NS = 240;
  localparam int DEB2_NS = 480;
  localparam int DEB3_NS = 640;
  // Open-loop margin in codes of an 11-bit full scale of 1600 mV
  localparam int FULL_SCALE_MV = 1600;
  localparam int OL_MARGIN_MV = 100;
  localparam logic [10:0] OL_MARGIN = 11'((2047 * OL_MARGIN_MV) / FULL_SCALE_MV);
  // Fault actions and the default code-to-action map (code i -> entry i)
  typedef enum logic [1:0] {ACT_SHUTDOWN, ACT_DISABLE, ACT_SOFT_START, ACT_IGNORE} action_t;
  localparam logic [7:0] ACTION_MAP_DEFAULT = 8'hE4;

  function automatic action_t map_action(input logic [7:0] amap, input logic [1:0] code);
    map_action = action_t'(amap[{code, 1'b0} +: 2]);
  endfunction

  function automatic logic [6:0] deb_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: deb_cycles = 7'(DEB0_NS / CLK_PERIOD_NS);
      2'h1: deb_cycles = 7'(DEB1_NS / CLK_PERIOD_NS);
      2'h2: deb_cycles = 7'(DEB2_NS / CLK_PERIOD_NS);
      default: deb_cycles = 7'(DEB3_NS / CLK_PERIOD_NS);
    endcase
  endfunction
endpackage

// ==== shared/fault_if.sv ====
/*
  Carrier between a fault source and its responder.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface fault_if;
  logic event_p;
  logic [1:0] code;
  logic clear;
  logic flag;
  logic halt;
  logic block;
  logic restart;
  modport source(output event_p, code, clear, input flag, halt, block, restart);
  modport responder(input event_p, code, clear, output flag, halt, block, restart);
endinterface

// ==== rtl/fault_responder.sv ====
/*
  Fault flag and programmed action for one fault source.
  Assumes power_on_request is synchronous to clk.
*/
`timescale 1ns/1ps
module fault_responder
  import ovp_pkg::*;
#(
  parameter logic [7:0] ACTION_MAP = ACTION_MAP_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic power_on_request,
  fault_if.responder f
);
  action_t act;
  logic pon_q;
  assign act = map_action(ACTION_MAP, f.code); // RULE18

  ////////////////////////////////////////////////////////////////////////
  // Flag: a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) f.flag <= 1'b0;
    else if (f.event_p) f.flag <= 1'b1;
    else if (f.clear) f.flag <= 1'b0;
  end

  // Actions; shutdown holds until a fresh power-on request edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pon_q <= 1'b0;
      f.halt <= 1'b0;
      f.block <= 1'b0;
      f.restart <= 1'b0;
    end else begin
      pon_q <= power_on_request;
      f.restart <= f.event_p && act == ACT_SOFT_START; // RULE14
      if (f.event_p && act == ACT_SHUTDOWN) f.halt <= 1'b1; // RULE14
      else if (power_on_request && !pon_q) f.halt <= 1'b0;
      if (f.event_p && act == ACT_DISABLE) f.block <= 1'b1; // RULE14
      else if (f.clear) f.block <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_set_wins;
    @(posedge clk) disable iff (!resetn) f.event_p |=> f.flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear"); // RULE7
  property p_disable_holds;
    @(posedge clk) disable iff (!resetn)
      f.event_p && act == ACT_DISABLE |=> f.block && f.flag;
  endproperty
  a_disable_holds: assert property (p_disable_holds) else $error("disable not applied"); // RULE14
endmodule // fault_responder

// ==== rtl/fast_trip_comparator.sv ====
/*
  Fast overvoltage comparator control: threshold select, blanking, debounce.
  Assumes comparator_high is the analog comparator output, already synchronous.
*/
`timescale 1ns/1ps
module fast_trip_comparator
  import ovp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic comparator_high,
  input wire logic [LEVEL_W-1:0] rise_level,
  input wire logic [LEVEL_W-1:0] fall_level,
  input wire logic [1:0] debounce_sel,
  output logic [LEVEL_W-1:0] dac_code,
  output logic trip,
  output logic above
);
  logic [6:0] deb_cnt;
  logic [9:0] blank_cnt;
  logic [LEVEL_W-1:0] target;
  logic blanking;
  assign blanking = blank_cnt != 10'h000;
  // Falling level only used when it differs from rising
  assign target = (above && fall_level != rise_level) ? fall_level : rise_level; // RULE12

  ////////////////////////////////////////////////////////////////////////
  // Threshold DAC and blanking on every threshold change
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dac_code <= RST_LEVEL[LEVEL_W-1:0];
      blank_cnt <= 10'h000;
    end else if (dac_code != target) begin
      dac_code <= target; // RULE10 RULE11
      blank_cnt <= 10'(BLANK_CYC); // RULE13
    end else if (blanking) begin
      blank_cnt <= blank_cnt - 10'h001;
    end
  end

  // Debounce: the new level must hold for the selected count
  always_ff @(posedge clk) begin
    if (!resetn) begin
      deb_cnt <= 7'h00;
      above <= 1'b0;
      trip <= 1'b0;
    end else begin
      trip <= 1'b0;
      if (blanking || comparator_high == above) begin
        deb_cnt <= 7'h00; // RULE13
      end else if (deb_cnt + 7'h01 >= deb_cycles(debounce_sel)) begin
        deb_cnt <= 7'h00; // RULE9
        above <= comparator_high;
        trip <= comparator_high; // RULE12
      end else begin
        deb_cnt <= deb_cnt + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_blank_switch;
    @(posedge clk) disable iff (!resetn) $changed(dac_code) |-> blanking ##1 !trip;
  endproperty
  a_blank_switch: assert property (p_blank_switch) else $error("no blanking after switch"); // RULE13
  property p_short_ignored;
    @(posedge clk) disable iff (!resetn) $rose(trip) |-> $past(comparator_high, 12);
  endproperty
  a_short_ignored: assert property (p_short_ignored) else $error("short pulse tripped"); // RULE9
  c_trip: cover property (@(posedge clk) disable iff (!resetn) trip ##[1:1000] $changed(dac_code));
endmodule // fast_trip_comparator

// ==== rtl/output_overvoltage_protection.sv ====
/*
  Output feedback averaging and overvoltage / open-loop protection.
  Assumes sampled feedback and redundant sense codes share one 11-bit scale,
  a one-cycle zero-crossing strobe from input sensing, and a simple
  synchronous register port.
*/
//
// How it works
// RULE1: 11-bit half-cycle average feeds normal loop
// RULE2: 10-bit average refreshed at 1.5 kHz
// RULE3: Zero crossings delimit each half line cycle
// RULE4: Average every feedback sample within half cycle
// RULE5: Accurate check uses half-cycle average only
// RULE6: Limit register holds dc average level
// RULE7: Exceeding limit sets flag and runs action
// RULE8: Hysteresis applies only with disable action
// RULE9: Debounce comparator by 120/240/480/640 ns
// RULE10: Rising trip level from 7-bit field
// RULE11: Falling release level from 7-bit field
// RULE12: Trip acts, then moves to release level
// RULE13: Blank comparator 10 us on threshold switch
// RULE14: Fast response: shutdown, disable, restart, ignore
// RULE15: Flag sense mismatch above about 100 mV
// RULE16: Mismatch must persist 10 us first
// RULE17: Open-loop response uses same four actions
// RULE18: One shared code-to-action map parameter
`timescale 1ns/1ps
module output_overvoltage_protection
  import ovp_pkg::*;
#(
  parameter int FAST_PERIOD = FAST_PERIOD_CYC,
  parameter logic [7:0] ACTION_MAP = ACTION_MAP_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [10:0] output_feedback_input,
  input wire logic feedback_valid,
  input wire logic [10:0] redundant_output_sense_input,
  input wire logic comparator_high,
  input wire logic line_zero_cross,
  input wire logic power_on_request,
  input wire logic fault_clear,
  input wire logic reg_write,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic [10:0] half_cycle_average,
  output logic half_cycle_ready,
  output logic [9:0] fast_average,
  output logic fast_ready,
  output logic [6:0] trip_dac_code,
  output logic accurate_ov_flag,
  output logic fast_ov_flag,
  output logic open_loop_fault,
  output logic switching_disable,
  output logic shutdown_hold,
  output logic soft_start_request
);
  // Registers
  logic [15:0] output_overvoltage_trip_level;
  logic [7:0] output_overvoltage_reaction;
  logic [7:0] fast_overvoltage_action_select;
  logic [7:0] open_loop_action_select;
  logic [7:0] fast_overvoltage_rising_level;
  logic [7:0] fast_overvoltage_falling_level;
  logic [7:0] fast_overvoltage_debounce_select;
  logic [7:0] accurate_overvoltage_hysteresis;
  // Averagers
  logic [26:0] half_sum;
  logic [15:0] half_cnt;
  logic [26:0] fast_sum;
  logic [15:0] fast_cnt;
  logic [16:0] fast_tmr;
  // Protection
  logic [10:0] sense_diff;
  logic [10:0] fb_hold;
  logic mismatch;
  logic [9:0] ol_cnt;
  logic fast_trip;
  logic fast_above;
  logic [6:0] dac_code;
  logic acc_disable_mode;
  logic acc_over;
  logic acc_release;

  fault_if acc_f ();
  fault_if fast_f ();
  fault_if ol_f ();

  // Sum over count; an empty window yields zero
  function automatic logic [10:0] window_avg(input logic [26:0] sum, input logic [15:0] cnt);
    logic [26:0] q;
    q = (cnt == 16'h0000) ? 27'h0000000 : sum / {11'h000, cnt};
    window_avg = q[10:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register writes; unknown offsets are ignored
  always_ff @(posedge clk) begin
    if (!resetn) begin
      output_overvoltage_trip_level <= RST_TRIP_LEVEL;
      output_overvoltage_reaction <= RST_BYTE;
      fast_overvoltage_action_select <= RST_BYTE;
      open_loop_action_select <= RST_BYTE;
      fast_overvoltage_rising_level <= RST_LEVEL;
      fast_overvoltage_falling_level <= RST_LEVEL;
      fast_overvoltage_debounce_select <= RST_BYTE;
      accurate_overvoltage_hysteresis <= RST_BYTE;
    end else if (reg_write) begin
      case (reg_addr)
        OFF_TRIP_LEVEL: output_overvoltage_trip_level <= reg_wdata; // RULE6
        OFF_REACTION: output_overvoltage_reaction <= reg_wdata[7:0];
        OFF_FAST_ACTION: fast_overvoltage_action_select <= reg_wdata[7:0];
        OFF_OL_ACTION: open_loop_action_select <= reg_wdata[7:0];
        OFF_FAST_RISE: fast_overvoltage_rising_level <= reg_wdata[7:0];
        OFF_FAST_FALL: fast_overvoltage_falling_level <= reg_wdata[7:0];
        OFF_FAST_DEB: fast_overvoltage_debounce_select <= reg_wdata[7:0];
        OFF_HYST: accurate_overvoltage_hysteresis <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Registered read-back; status shows live protection state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else begin
      case (reg_addr)
        OFF_TRIP_LEVEL: reg_rdata <= output_overvoltage_trip_level;
        OFF_REACTION: reg_rdata <= {8'h00, output_overvoltage_reaction};
        OFF_FAST_ACTION: reg_rdata <= {8'h00, fast_overvoltage_action_select};
        OFF_OL_ACTION: reg_rdata <= {8'h00, open_loop_action_select};
        OFF_FAST_RISE: reg_rdata <= {9'h000, fast_overvoltage_rising_level[6:0]};
        OFF_FAST_FALL: reg_rdata <= {9'h000, fast_overvoltage_falling_level[6:0]};
        OFF_FAST_DEB: reg_rdata <= {14'h0000, fast_overvoltage_debounce_select[1:0]};
        OFF_HYST: reg_rdata <= {8'h00, accurate_overvoltage_hysteresis};
        OFF_STATUS: reg_rdata <= {10'h000, fast_above, mismatch, acc_f.flag,
                                  fast_f.flag, ol_f.flag, acc_f.block};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Half-cycle prefilter: sample arriving with the crossing opens the next window
  always_ff @(posedge clk) begin
    if (!resetn) begin
      half_sum <= 27'h0000000;
      half_cnt <= 16'h0000;
      half_cycle_average <= 11'h000;
      half_cycle_ready <= 1'b0;
    end else begin
      half_cycle_ready <= 1'b0;
      if (line_zero_cross) begin // RULE3
        half_sum <= feedback_valid ? {16'h0000, output_feedback_input} : 27'h0000000;
        half_cnt <= feedback_valid ? 16'h0001 : 16'h0000;
        if (half_cnt != 16'h0000) begin
          half_cycle_average <= window_avg(half_sum, half_cnt); // RULE4 RULE1
          half_cycle_ready <= 1'b1; // RULE1
        end
      end else if (feedback_valid && half_cnt != 16'hFFFF) begin
        half_sum <= half_sum + {16'h0000, output_feedback_input}; // RULE4
        half_cnt <= half_cnt + 16'h0001;
      end
    end
  end

  // Fast stream: average over a fixed 1.5 kHz window, top 10 bits kept
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fast_sum <= 27'h0000000;
      fast_cnt <= 16'h0000;
      fast_tmr <= 17'h00000;
      fast_average <= 10'h000;
      fast_ready <= 1'b0;
    end else begin
      fast_ready <= 1'b0;
      if (fast_tmr == 17'(FAST_PERIOD - 1)) begin
        fast_tmr <= 17'h00000;
        fast_sum <= 27'h0000000;
        fast_cnt <= 16'h0000;
        if (fast_cnt != 16'h0000) begin
          fast_average <= 10'(window_avg(fast_sum, fast_cnt) >> 1); // RULE2
          fast_ready <= 1'b1; // RULE2
        end
      end else begin
        fast_tmr <= fast_tmr + 17'h00001;
        if (feedback_valid && fast_cnt != 16'hFFFF) begin
          fast_sum <= fast_sum + {16'h0000, output_feedback_input};
          fast_cnt <= fast_cnt + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accurate check: only on a fresh half-cycle average, so it is slow by design
  assign acc_disable_mode = map_action(ACTION_MAP,
      output_overvoltage_reaction[ACT_LSB +: 2]) == ACT_DISABLE; // RULE18
  assign acc_over = half_cycle_ready
      && half_cycle_average > output_overvoltage_trip_level[10:0]; // RULE5 RULE6
  // Release below limit minus hysteresis; without disable, release is software only
  assign acc_release = half_cycle_ready && acc_disable_mode
      && {1'b0, half_cycle_average} + {4'h0, accurate_overvoltage_hysteresis}
         < {1'b0, output_overvoltage_trip_level[10:0]}; // RULE8
  assign acc_f.event_p = acc_over && (!acc_f.flag || fault_clear); // RULE7
  assign acc_f.code = output_overvoltage_reaction[ACT_LSB +: 2]; // RULE7
  assign acc_f.clear = fault_clear || acc_release; // RULE8

  fault_responder #(.ACTION_MAP(ACTION_MAP)) acc_resp (
    .clk(clk),
    .resetn(resetn),
    .power_on_request(power_on_request),
    .f(acc_f)
  );

  ////////////////////////////////////////////////////////////////////////
  // Fast comparator path
  fast_trip_comparator fast_cmp (
    .clk(clk),
    .resetn(resetn),
    .comparator_high(comparator_high),
    .rise_level(fast_overvoltage_rising_level[6:0]),
    .fall_level(fast_overvoltage_falling_level[6:0]),
    .debounce_sel(fast_overvoltage_debounce_select[1:0]),
    .dac_code(dac_code),
    .trip(fast_trip),
    .above(fast_above)
  );
  assign fast_f.event_p = fast_trip; // RULE12
  assign fast_f.code = fast_overvoltage_action_select[ACT_LSB +: 2]; // RULE14
  assign fast_f.clear = fault_clear;

  fault_responder #(.ACTION_MAP(ACTION_MAP)) fast_resp (
    .clk(clk),
    .resetn(resetn),
    .power_on_request(power_on_request),
    .f(fast_f)
  );

  ////////////////////////////////////////////////////////////////////////
  // Open-loop: the two dividers should agree; a lasting gap means a broken divider
  // Last valid sample; the feedback bus is undefined between strobes
  always_ff @(posedge clk) begin
    if (!resetn) fb_hold <= 11'h000;
    else if (feedback_valid) fb_hold <= output_feedback_input;
  end
  assign sense_diff = (redundant_output_sense_input > fb_hold)
      ? redundant_output_sense_input - fb_hold
      : fb_hold - redundant_output_sense_input;
  assign mismatch = sense_diff > OL_MARGIN; // RULE15

  always_ff @(posedge clk) begin
    if (!resetn) ol_cnt <= 10'h000;
    else if (!mismatch) ol_cnt <= 10'h000; // RULE16
    else if (ol_cnt != 10'(OL_DEB_CYC)) ol_cnt <= ol_cnt + 10'h001;
  end
  assign ol_f.event_p = mismatch && ol_cnt == 10'(OL_DEB_CYC - 1); // RULE16
  assign ol_f.code = open_loop_action_select[ACT_LSB +: 2]; // RULE17
  assign ol_f.clear = fault_clear;

  fault_responder #(.ACTION_MAP(ACTION_MAP)) ol_resp (
    .clk(clk),
    .resetn(resetn),
    .power_on_request(power_on_request),
    .f(ol_f)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output stage: every protection output leaves from a flop here
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trip_dac_code <= RST_LEVEL[6:0];
      accurate_ov_flag <= 1'b0;
      fast_ov_flag <= 1'b0;
      open_loop_fault <= 1'b0;
      switching_disable <= 1'b0;
      shutdown_hold <= 1'b0;
      soft_start_request <= 1'b0;
    end else begin
      trip_dac_code <= dac_code; // RULE10
      accurate_ov_flag <= acc_f.flag; // RULE7
      fast_ov_flag <= fast_f.flag;
      open_loop_fault <= ol_f.flag;
      switching_disable <= acc_f.block || fast_f.block || ol_f.block; // RULE14
      shutdown_hold <= acc_f.halt || fast_f.halt || ol_f.halt; // RULE14
      soft_start_request <= acc_f.restart || fast_f.restart || ol_f.restart; // RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_half_ready;
    line_zero_cross && half_cnt != 16'h0000 |=> half_cycle_ready
      && half_cycle_average == window_avg($past(half_sum), $past(half_cnt));
  endproperty
  a_half_ready: assert property (p_half_ready) else $error("half-cycle average missing"); // RULE4

  property p_half_only_at_cross;
    half_cycle_ready |-> $past(line_zero_cross);
  endproperty
  a_half_only_at_cross: assert property (p_half_only_at_cross) else $error("stray half result"); // RULE3

  property p_fast_spacing;
    fast_ready |=> !fast_ready [*8];
  endproperty
  a_fast_spacing: assert property (p_fast_spacing) else $error("fast result too close"); // RULE2

  property p_acc_trip;
    acc_over |-> ##2 accurate_ov_flag;
  endproperty
  a_acc_trip: assert property (p_acc_trip) else $error("accurate flag not raised"); // RULE7

  property p_acc_slow;
    $rose(acc_f.flag) |-> $past(half_cycle_ready);
  endproperty
  a_acc_slow: assert property (p_acc_slow) else $error("accurate flag off a half cycle"); // RULE5

  property p_ol_deb;
    $rose(ol_f.flag) |-> $past(mismatch) && $past(ol_cnt) == 10'(OL_DEB_CYC - 1);
  endproperty
  a_ol_deb: assert property (p_ol_deb) else $error("open-loop flag before debounce"); // RULE16

  property p_ol_reset;
    !mismatch |=> ol_cnt == 10'h000;
  endproperty
  a_ol_reset: assert property (p_ol_reset) else $error("debounce kept over a gap"); // RULE16

  property p_fast_flag;
    fast_trip |-> ##2 fast_ov_flag;
  endproperty
  a_fast_flag: assert property (p_fast_flag) else $error("fast trip not flagged"); // RULE12

  c_half: cover property (half_cycle_ready ##[1:1000] acc_over);
  c_ol: cover property ($rose(open_loop_fault));
  c_hyst: cover property (acc_release && acc_f.flag);
endmodule // output_overvoltage_protection

// ==== tb/power_stage_model.sv ====
/*
  Boost stage model: divided feedback samples, redundant sense, comparator, line crossings.
  Assumes the bench sets the output level, the sense mismatch and comparator glitches.
*/
`timescale 1ns/1ps
module power_stage_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [10:0] vout,
  input wire logic [10:0] offset,
  input wire logic glitch,
  input wire logic [6:0] dac_code,
  output logic [10:0] feedback,
  output logic valid,
  output logic [10:0] sense,
  output logic comp_high,
  output logic zero_cross
);
  logic [5:0] cnt;
  logic [10:0] sample;
  ////////////////////////////////////////////////////////////
  // Two-code ripple on alternate samples, so the average is not trivial
  assign sample = vout + ((cnt[2] == 1'b1) ? 11'h002 : 11'h000);
  // Sample every 4 cycles, crossing every 64; feedback garbled off the strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt <= 6'h00;
      valid <= 1'b0;
      feedback <= 11'h000;
      zero_cross <= 1'b0;
      sense <= 11'h000;
      comp_high <= 1'b0;
    end else begin
      cnt <= cnt + 6'h01;
      valid <= (cnt[1:0] == 2'h0);
      feedback <= (cnt[1:0] == 2'h0) ? sample : ~sample;
      zero_cross <= (cnt == 6'h3F);
      sense <= vout + offset;
      // Coarse scale: top 7 bits of the level against the threshold code
      comp_high <= (vout[10:4] > dac_code) | glitch;
    end
  end
endmodule // power_stage_model

// ==== tb/testbench.sv ====
/*
  Self-checking bench for output_overvoltage_protection with a boost stage model.
  Assumes the fast update period parameter is shortened to 20 cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module testbench;
  import ovp_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [10:0] vout = 11'h200;
  logic [10:0] offset = 11'h000;
  logic glitch = 1'b0;
  logic power_on_request = 1'b0;
  logic fault_clear = 1'b0;
  logic reg_write = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, rv;
  logic [10:0] fb, sense, half_cycle_average;
  logic [9:0] fast_average;
  logic [6:0] trip_dac_code;
  logic fb_valid, comp_high, zero_cross, half_cycle_ready, fast_ready, accurate_ov_flag;
  logic fast_ov_flag, open_loop_fault, switching_disable, shutdown_hold, soft_start_request;
  int n_fail = 0;
  int checks_done = 0;
  int n_ss = 0;
  int n;
  ////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(posedge clk) if (soft_start_request === 1'b1) n_ss++;
  power_stage_model stage (.clk(clk), .resetn(resetn), .vout(vout), .offset(offset),
    .glitch(glitch), .dac_code(trip_dac_code), .feedback(fb), .valid(fb_valid),
    .sense(sense), .comp_high(comp_high), .zero_cross(zero_cross));
  output_overvoltage_protection #(.FAST_PERIOD(20)) dut (.clk(clk), .resetn(resetn),
    .output_feedback_input(fb), .feedback_valid(fb_valid),
    .redundant_output_sense_input(sense), .comparator_high(comp_high),
    .line_zero_cross(zero_cross), .power_on_request(power_on_request),
    .fault_clear(fault_clear), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .half_cycle_average(half_cycle_average),
    .half_cycle_ready(half_cycle_ready), .fast_average(fast_average), .fast_ready(fast_ready),
    .trip_dac_code(trip_dac_code), .accurate_ov_flag(accurate_ov_flag),
    .fast_ov_flag(fast_ov_flag), .open_loop_fault(open_loop_fault),
    .switching_disable(switching_disable), .shutdown_hold(shutdown_hold),
    .soft_start_request(soft_start_request));
  ////////////////////////////////////////////////////////////
  // Shared steps; inputs always change 1 ns after the rising edge
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task do_reset;
    cyc(1);
    resetn = 1'b0;
    vout = 11'h200;
    offset = 11'h000;
    cyc(5);
    resetn = 1'b1;
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    cyc(1);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    cyc(1);
    reg_write = 1'b0;
  endtask
  task rd(input logic [15:0] a, output logic [15:0] d);
    cyc(1);
    reg_addr = a;
    cyc(2);
    d = reg_rdata;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  // Bounded wait for a ready pulse; returns the cycles it took
  task wait_ready(input bit fast, output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (((fast ? fast_ready : half_cycle_ready) !== 1'b1) && k < 500);
  endtask
  ////////////////////////////////////////////////////////////
  // Reset values, field widths, unmapped place
  task test_regs;
    logic [15:0] ra [10] = '{16'h0040, 16'hFE2F, 16'hFE30, 16'h0041, 16'hFE01, 16'hFE02,
      16'hFE31, 16'hFE50, 16'h1234, 16'hFE31};
    logic [15:0] re [10] = '{16'h07FF, 16'h007F, 16'h007F, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0003};
    do_reset;
    `CHK("dac_rst", 7'h7F, trip_dac_code)
    wr(16'h1234, 16'hFFFF);
    for (int i = 0; i < 10; i++) begin
      if (i == 9) wr(16'hFE31, 16'hFFFF);
      rd(ra[i], rv);
      `CHK("reg", re[i], rv)
    end
  endtask
  // Half-cycle and fast averages with ripple, window spacing
  task test_average;
    do_reset;
    wait_ready(1'b0, n);
    wait_ready(1'b0, n);
    `CHK("half_gap", 64, n)
    `CHK("half_avg", 11'h201, half_cycle_average)
    wait_ready(1'b1, n);
    wait_ready(1'b1, n);
    `CHK("fast_gap", 20, n)
    `CHK("fast_avg", 10'h100, fast_average)
  endtask
  // Debounce, threshold swap, blanking, shutdown until power-on request
  task test_fast;
    do_reset;
    wr(16'hFE2F, 16'h0040);
    wr(16'hFE30, 16'h0030);
    wr(16'hFE31, 16'h0003);
    cyc(1100);
    glitch = 1'b1;
    cyc(63);
    glitch = 1'b0;
    cyc(80);
    `CHK("short_glitch", 1'b0, fast_ov_flag)
    vout = 11'h420;
    cyc(100);
    `CHK("fast_flag", 1'b1, fast_ov_flag)
    `CHK("hold", 1'b1, shutdown_hold)
    `CHK("dac_fall", 7'h30, trip_dac_code)
    vout = 11'h200;
    cyc(500);
    `CHK("dac_blank", 7'h30, trip_dac_code)
    cyc(700);
    `CHK("dac_rise", 7'h40, trip_dac_code)
    pulse(power_on_request);
    cyc(3);
    `CHK("hold_rel", 1'b0, shutdown_hold)
    pulse(fault_clear);
    cyc(3);
    `CHK("fast_clr", 1'b0, fast_ov_flag)
  endtask
  // Limit, disable action with hysteresis release, ignore action stays set
  task test_accurate;
    do_reset;
    wr(16'h0040, 16'h0300);
    wr(16'h0041, 16'h0040);
    wr(16'hFE50, 16'h0010);
    vout = 11'h310;
    cyc(300);
    `CHK("acc_flag", 1'b1, accurate_ov_flag)
    `CHK("acc_dis", 1'b1, switching_disable)
    rd(16'hFE90, rv);
    `CHK("status", 16'h0009, rv)
    vout = 11'h2F0;
    cyc(300);
    `CHK("acc_hyst", 1'b1, accurate_ov_flag)
    vout = 11'h2E0;
    cyc(300);
    `CHK("acc_rel", 1'b0, accurate_ov_flag)
    wr(16'h0041, 16'h00C0);
    vout = 11'h310;
    cyc(300);
    vout = 11'h2E0;
    cyc(300);
    `CHK("acc_keep", 1'b1, accurate_ov_flag)
    `CHK("acc_ign", 1'b0, switching_disable)
  endtask
  // Mismatch must persist before the soft-start action fires once
  task test_open_loop;
    do_reset;
    wr(16'hFE02, 16'h0080);
    n_ss = 0;
    offset = 11'd200;
    cyc(900);
    offset = 11'h000;
    cyc(5);
    `CHK("ol_short", 1'b0, open_loop_fault)
    offset = 11'd200;
    cyc(1100);
    `CHK("ol_flag", 1'b1, open_loop_fault)
    `CHK("ol_ss", 1, n_ss)
  endtask
  ////////////////////////////////////////////////////////////
  task finish_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Run takes about 63 us; cut off well beyond that
  initial begin
    #500_000;
    n_fail++;
    finish_test;
  end
  initial begin
    test_regs;
    test_average;
    test_fast;
    test_accurate;
    test_open_loop;
    finish_test;
  end
endmodule // testbench
